// [logic/lsrt_load_switch_reset_timer.sv]
`default_nettype none
module lsrt_load_switch_reset_timer
   import lsrt_pkg::*;
#(
   parameter int unsigned LONG_PRESS_CNT = LONG_PRESS_US,
   parameter int unsigned TURNOFF_T      = TURNOFF_CNT,
   parameter int unsigned LOCKOUT_T      = LOCKOUT_CNT
)(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       reset_button_n,
   input  wire logic       wake_input,
   input  wire logic       turn_off_n,
   input  wire logic       delay_select,
   input  wire logic [2:0] delay_scale_input,
   input  wire logic       delay_scale_enable,
   output logic            load_on,
   output logic            test_mode
);
   import lsrt_pkg::*;

   logic             tick_us;
   lsrt_state_t      state_q;
   logic             btn_q;
   logic             wake_q;
   logic             off_q;
   logic             dsel_q;
   logic             dsel_at_press_q;
   logic             armed_q;
   logic             off_edge_q;
   logic [CNT_W-1:0] press_cnt_q;
   logic [CNT_W-1:0] qual_cnt_q;
   logic [CNT_W-1:0] dly_cnt_q;
   logic [CNT_W-1:0] long_lim;
   logic [3:0]       scale_qtr;
   logic             btn_fall;
   logic             wake_rise;
   logic             off_fall;
   logic             press_on;
   logic             press_rst;
   logic             off_ok;
   logic             off_dly_done;

   lsrt_tick u_tick (
      .clock   (clock),
      .rst_n   (rst_n),
      .tick_us (tick_us)
   );

   // Input state registers with documented defaults
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         btn_q  <= 1'b1;
         dsel_q <= 1'b1;
         wake_q <= 1'b0;
         off_q  <= 1'b1;
      end else begin
         btn_q  <= reset_button_n;
         dsel_q <= delay_select;
         wake_q <= wake_input;
         off_q  <= turn_off_n;
      end
   end

   assign btn_fall  = btn_q && !reset_button_n;
   assign wake_rise = !wake_q && wake_input;
   assign off_fall  = off_q && !turn_off_n;

   // Multiplier in quarters: code plus two, 1.00 when adjustment off
   always_comb begin
      if (!delay_scale_enable || delay_scale_input > 3'h6) begin
         scale_qtr = {1'b0, SCALE_DEFAULT} + SCALE_BASE_Q;
      end else begin
         scale_qtr = {1'b0, delay_scale_input} + SCALE_BASE_Q;
      end
   end

   // Scaled long-press limit in us
   assign long_lim = CNT_W'((LONG_PRESS_CNT / 4) * scale_qtr);

   // Inverted delay select latched as the button falls
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dsel_at_press_q <= 1'b0;
      end else if (btn_fall) begin
         dsel_at_press_q <= !dsel_q;
      end
   end

   // Button press duration counter; clears on release
   always_ff @(posedge clock) begin
      if (!rst_n || reset_button_n) begin
         press_cnt_q <= '0;
      end else if (tick_us && press_cnt_q != '1) begin
         press_cnt_q <= press_cnt_q + 1'b1;
      end
   end

   assign press_on  = dsel_at_press_q
                      ? press_cnt_q >= CNT_W'(TURN_ON_FAST_CNT)
                      : press_cnt_q > CNT_W'(TURN_ON_CNT);
   assign press_rst = armed_q && (dsel_at_press_q
                      ? press_cnt_q >= CNT_W'(LONG_FAST_CNT)
                      : press_cnt_q >= long_lim);

   // Reset arming: off after turn-on until release
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         armed_q <= 1'b1;
      end else if (state_q == LSRT_OFF && press_on) begin
         armed_q <= 1'b0;
      end else if (reset_button_n) begin
         armed_q <= 1'b1;
      end
   end

   // Off request qualification: low for 1 ms after edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         off_edge_q <= 1'b0;
         qual_cnt_q <= '0;
      end else if (turn_off_n) begin
         off_edge_q <= 1'b0;
         qual_cnt_q <= '0;
      end else if (state_q != LSRT_ON) begin
         off_edge_q <= 1'b0;
         qual_cnt_q <= '0;
      end else if (off_fall && state_q == LSRT_ON) begin
         off_edge_q <= 1'b1;
         qual_cnt_q <= '0;
      end else if (off_edge_q && tick_us) begin
         qual_cnt_q <= qual_cnt_q + 1'b1;
      end
   end

   assign off_ok = off_edge_q && qual_cnt_q >= CNT_W'(OFF_QUAL_CNT);

   assign off_dly_done = dsel_q
                         ? dly_cnt_q >= CNT_W'(TURNOFF_T)
                         : dly_cnt_q >= CNT_W'(TURNOFF_FAST_CNT);

   // Main sequencer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q   <= LSRT_ON;
         dly_cnt_q <= '0;
         test_mode <= 1'b0;
      end else begin
         case (state_q)
            LSRT_ON: begin
               dly_cnt_q <= '0;
               if (!reset_button_n) begin
                  if (press_rst) begin
                     test_mode <= dsel_at_press_q;
                     state_q   <= LSRT_LOCK;
                  end
               end else if (!wake_input && off_ok) begin
                  state_q <= LSRT_OFF_DLY;
               end
            end
            LSRT_OFF_DLY: begin
               if (btn_fall || wake_rise) begin
                  state_q <= LSRT_ON;
               end else if (off_dly_done) begin
                  state_q   <= LSRT_OFF;
                  dly_cnt_q <= '0;
               end else if (tick_us) begin
                  dly_cnt_q <= dly_cnt_q + 1'b1;
               end
            end
            LSRT_OFF: begin
               dly_cnt_q <= '0;
               if (!reset_button_n && press_on) begin
                  state_q <= LSRT_ON;
               end else if (reset_button_n && wake_input) begin
                  state_q <= LSRT_ON;
               end
            end
            LSRT_LOCK: begin
               if (dly_cnt_q >= CNT_W'(LOCKOUT_T)) begin
                  state_q   <= LSRT_WAIT_HI;
                  dly_cnt_q <= '0;
               end else if (tick_us) begin
                  dly_cnt_q <= dly_cnt_q + 1'b1;
               end
            end
            LSRT_WAIT_HI: begin
               if (reset_button_n) begin
                  state_q   <= LSRT_OFF;
                  test_mode <= 1'b0;
               end
            end
            default: begin
               state_q <= LSRT_ON;
            end
         endcase
      end
   end

   // Load switch drive
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         load_on <= 1'b1;
      end else begin
         load_on <= (state_q == LSRT_ON) || (state_q == LSRT_OFF_DLY);
      end
   end
endmodule : lsrt_load_switch_reset_timer
`default_nettype wire

// [logic/lsrt_pkg.sv]
`default_nettype none
package lsrt_pkg;
   // Clock rate
   localparam int unsigned CLK_HZ         = 25_000_000;
   // Times in microseconds as printed
   localparam int unsigned OFF_QUAL_US    = 1_000;
   localparam int unsigned TURNOFF_US     = 900_000;
   localparam int unsigned TURNOFF_FAST_US = 600;
   localparam int unsigned TURN_ON_US     = 38_000;
   localparam int unsigned TURN_ON_FAST_US = 4_000;
   localparam int unsigned LONG_PRESS_US  = 11_500_000;
   localparam int unsigned LONG_FAST_US   = 1_000;
   localparam int unsigned LOCKOUT_US     = 400_000;
   // Clock cycles per microsecond tick divider
   localparam int unsigned TICK_DIV       = CLK_HZ / 1_000_000;
   // Counts in microsecond ticks (the 1 us enable)
   localparam int unsigned OFF_QUAL_CNT   = OFF_QUAL_US;
   localparam int unsigned TURNOFF_CNT    = TURNOFF_US;
   localparam int unsigned TURNOFF_FAST_CNT = TURNOFF_FAST_US;
   localparam int unsigned TURN_ON_CNT    = TURN_ON_US;
   localparam int unsigned TURN_ON_FAST_CNT = TURN_ON_FAST_US;
   localparam int unsigned LONG_FAST_CNT  = LONG_FAST_US;
   localparam int unsigned LOCKOUT_CNT    = LOCKOUT_US;
   // Counter width for microsecond counts up to 2x long press
   localparam int unsigned CNT_W          = 25;
   // Multiplier in quarters: code 0..6 gives 0.50..2.00, default 1.00
   localparam logic [2:0] SCALE_DEFAULT   = 3'h2;
   localparam logic [3:0] SCALE_BASE_Q    = 4'h2;
   localparam int unsigned DIV_W          = 5;
   // Sequencer states, Gray along on -> pending off -> off -> lockout
   typedef enum logic [2:0] {
      LSRT_ON      = 3'b000,
      LSRT_OFF_DLY = 3'b001,
      LSRT_OFF     = 3'b011,
      LSRT_LOCK    = 3'b010,
      LSRT_WAIT_HI = 3'b110
   } lsrt_state_t;
endpackage : lsrt_pkg
`default_nettype wire

// [logic/lsrt_tick.sv]
`default_nettype none
module lsrt_tick
   import lsrt_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst_n,
   output logic      tick_us
);
   logic [DIV_W-1:0] div_q;

   // Free-running 1 us enable from the 25 MHz clock
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         div_q   <= '0;
         tick_us <= 1'b0;
      end else if (div_q == DIV_W'(TICK_DIV - 1)) begin
         div_q   <= '0;
         tick_us <= 1'b1;
      end else begin
         div_q   <= div_q + 1'b1;
         tick_us <= 1'b0;
      end
   end
endmodule : lsrt_tick
`default_nettype wire

// [tb/lsrt_assertions.sv]
`default_nettype none
module lsrt_assertions #(
   parameter int unsigned LONG_PRESS_CNT = 2000
)(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic reset_button_n,
   input wire logic wake_input,
   input wire logic turn_off_n,
   input wire logic delay_select,
   input wire logic load_on,
   input wire logic test_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] off_low_q;
   logic [15:0] btn_low_q;
   // Saturating count of cycles the off line has been low
   always_ff @(posedge clock) begin
      if (!rst_n || turn_off_n) off_low_q <= 16'h0000;
      else if (~&off_low_q) off_low_q <= off_low_q + 16'h0001;
   end
   // Saturating count of cycles the button has been held
   always_ff @(posedge clock) begin
      if (!rst_n || reset_button_n) btn_low_q <= 16'h0000;
      else if (~&btn_low_q) btn_low_q <= btn_low_q + 16'h0001;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Load dropped while the button is held
   sequence s_press_off;
      $fell(load_on) && !reset_button_n;
   endsequence
   a_reset_load_on: assert property ($rose(rst_n) |-> load_on)
      else $error("load off after reset");
   a_reset_no_test: assert property ($rose(rst_n) |-> !test_mode)
      else $error("test mode set after reset");
   a_off_qualified: assert property ($fell(load_on) && reset_button_n |->
      off_low_q >= 16'h61A8)
      else $error("turn-off without 1 ms low off line");
   a_rise_has_cause: assert property ($rose(load_on) |->
      wake_input || !reset_button_n)
      else $error("load on without wake or press");
   a_lockout_holds: assert property (s_press_off |=> !load_on [*8])
      else $error("load back on inside lockout");
   a_press_not_early: assert property (s_press_off ##0 delay_select |->
      btn_low_q >= (LONG_PRESS_CNT - 1) * lsrt_pkg::TICK_DIV)
      else $error("long press cut off too early");
   a_test_needs_press: assert property ($rose(test_mode) |->
      !reset_button_n)
      else $error("test mode without press");
   a_test_ends_release: assert property ($fell(test_mode) |->
      reset_button_n)
      else $error("test mode left while pressed");
endmodule : lsrt_assertions
bind lsrt_load_switch_reset_timer lsrt_assertions #(
   .LONG_PRESS_CNT(LONG_PRESS_CNT)
) u_assertions (
   .clock(clock), .rst_n(rst_n), .reset_button_n(reset_button_n),
   .wake_input(wake_input), .turn_off_n(turn_off_n),
   .delay_select(delay_select), .load_on(load_on), .test_mode(test_mode)
);
`default_nettype wire

// [tb/lsrt_partner.sv]
`default_nettype none
module lsrt_partner (
   input  wire logic clock,
   input  wire logic press,
   input  wire logic wake_req,
   input  wire logic off_req,
   output var logic  reset_button_n,
   output var logic  wake_input,
   output var logic  turn_off_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle levels of button, wake and off lines
   initial begin
      reset_button_n = 1'b1;
      wake_input = 1'b0;
      turn_off_n = 1'b1;
   end
   // Lines follow the requests at falling edges
   always @(negedge clock) begin
      reset_button_n <= !press;
      wake_input <= wake_req;
      turn_off_n <= !off_req;
   end
endmodule : lsrt_partner
`default_nettype wire

// [tb/lsrt_load_switch_reset_timer_test.sv]
`default_nettype none
module lsrt_load_switch_reset_timer_test import lsrt_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned LP_T = 200;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic press = 1'b0;
   logic wake_req = 1'b0;
   logic off_req = 1'b0;
   logic delay_select = 1'b1;
   wire logic reset_button_n, wake_input, turn_off_n, load_on, test_mode;
   int errors = 0;
   int comparisons = 0;
   lsrt_load_switch_reset_timer #(
      .LONG_PRESS_CNT(LP_T), .TURNOFF_T(100), .LOCKOUT_T(100)
   ) dut (
      .clock(clock), .rst_n(rst_n), .reset_button_n(reset_button_n),
      .wake_input(wake_input), .turn_off_n(turn_off_n),
      .delay_select(delay_select), .delay_scale_input(3'h0),
      .delay_scale_enable(1'b0), .load_on(load_on), .test_mode(test_mode)
   );
   lsrt_partner u_partner (
      .clock(clock), .press(press), .wake_req(wake_req), .off_req(off_req),
      .reset_button_n(reset_button_n), .wake_input(wake_input),
      .turn_off_n(turn_off_n)
   );
   always #20 clock = ~clock;
   task automatic check(input string what, input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : check
   task automatic wait_us(input int n);
      repeat (n * TICK_DIV) @(negedge clock);
   endtask : wait_us
   task automatic final_report;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   // Wake turns the load on; bounded wait
   task automatic t_wake_on;
      wake_req = 1'b1;
      for (int i = 0; i < 5000 && load_on !== 1'b1; i++) wait_us(1);
      wake_req = 1'b0;
      check("load_on wake", load_on, 1'b1);
      wait_us(20);
   endtask : t_wake_on
   // Short presses must not add up
   task automatic t_early;
      press = 1'b1;
      wait_us(LP_T / 2);
      press = 1'b0;
      wait_us(20);
      press = 1'b1;
      wait_us(LP_T * 3 / 4);
      press = 1'b0;
      wait_us(20);
      check("load_on early", load_on, 1'b1);
   endtask : t_early
   // Wake inside the pending turn-off aborts it
   task automatic t_abort;
      off_req = 1'b1;
      wait_us(1020);
      wake_req = 1'b1;
      wait_us(20);
      wake_req = 1'b0;
      wait_us(150);
      check("load_on abort", load_on, 1'b1);
      off_req = 1'b0;
      wait_us(10);
   endtask : t_abort
   // Qualified off edge, then the turn-off delay
   task automatic t_delay_off;
      off_req = 1'b1;
      wait_us(1050);
      check("load_on pending", load_on, 1'b1);
      wait_us(100);
      check("load_on off", load_on, 1'b0);
      off_req = 1'b0;
   endtask : t_delay_off
   // Long press turns off; inputs ignored until release
   task automatic t_long_press;
      press = 1'b1;
      wait_us(LP_T * 9 / 10);
      check("load_on held", load_on, 1'b1);
      wait_us(LP_T / 5);
      check("load_on press", load_on, 1'b0);
      wake_req = 1'b1;
      wait_us(10);
      wake_req = 1'b0;
      wait_us(120);
      check("load_on pressed", load_on, 1'b0);
      press = 1'b0;
      wait_us(20);
      check("load_on release", load_on, 1'b0);
      t_wake_on;
   endtask : t_long_press
   // Test mode: fast reset, lockout keeps its length
   task automatic t_test;
      delay_select = 1'b0;
      wait_us(5);
      press = 1'b1;
      wait_us(1030);
      check("load_on test", load_on, 1'b0);
      check("test_mode", test_mode, 1'b1);
      press = 1'b0;
      wait_us(10);
      wake_req = 1'b1;
      wait_us(10);
      wake_req = 1'b0;
      wait_us(20);
      check("load_on lockout", load_on, 1'b0);
      check("test_mode lockout", test_mode, 1'b1);
      wait_us(60);
      check("test_mode release", test_mode, 1'b0);
      check("load_on after lockout", load_on, 1'b0);
      delay_select = 1'b1;
      wait_us(20);
      t_wake_on;
   endtask : t_test
   // Watchdog
   initial begin
      wait_us(5000);
      errors++;
      $display("ERROR watchdog expired");
      final_report;
   end
   // Main sequence
   initial begin
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      wait_us(2);
      check("load_on por", load_on, 1'b1);
      check("test_mode por", test_mode, 1'b0);
      t_early;
      t_abort;
      t_delay_off;
      t_wake_on;
      t_long_press;
      t_test;
      final_report;
   end
endmodule : lsrt_load_switch_reset_timer_test
`default_nettype wire
